// ===== hdl/stl_pkg.sv
// Constants, register map and carrier types for the servo torque limit selector.
// Assumes a single 200 MHz clock and a simple strobe register port.
package stl_pkg;
  // Timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int SAMPLE_DELAY_NS = 2_000_000;
  localparam int SAMPLE_CYC      = SAMPLE_DELAY_NS / CLK_PERIOD_NS;
  localparam int FILT_UNIT_NS    = 10_000;
  localparam int FILT_TICK_CYC   = FILT_UNIT_NS / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] ADDR_FWD_INT   = 8'h00;
  localparam logic [7:0] ADDR_REV_INT   = 8'h04;
  localparam logic [7:0] ADDR_FWD_EXT   = 8'h08;
  localparam logic [7:0] ADDR_REV_EXT   = 8'h0C;
  localparam logic [7:0] ADDR_GAIN      = 8'h10;
  localparam logic [7:0] ADDR_FILT_TC   = 8'h14;
  localparam logic [7:0] ADDR_CFG       = 8'h18;
  localparam logic [7:0] ADDR_IN_MAP    = 8'h1C;
  localparam logic [7:0] ADDR_VIRT_MAP  = 8'h20;
  localparam logic [7:0] ADDR_INVERT    = 8'h24;
  localparam logic [7:0] ADDR_BUS_EN    = 8'h28;
  localparam logic [7:0] ADDR_VIRT_IN   = 8'h2C;
  localparam logic [7:0] ADDR_STATUS    = 8'h30;
  localparam logic [7:0] ADDR_EFF_LIM   = 8'h34;
  localparam logic [7:0] ADDR_TORQUE    = 8'h38;
  localparam logic [7:0] ADDR_OUT_ALLOC = 8'h3C;

  // Field positions
  localparam int CFG_ANALOG_EN_BIT = 0;
  localparam int CFG_RESTART_BIT   = 1;
  localparam int EFF_REV_LSB       = 16;
  localparam int BUS_HIGH_LSB      = 4;

  // Ranges and reset values, percent of rated torque unless noted
  localparam logic [9:0]  LIMIT_MAX       = 10'h190;
  localparam logic [9:0]  INT_LIMIT_RST   = 10'h15E;
  localparam logic [9:0]  EXT_LIMIT_RST   = 10'h064;
  localparam logic [9:0]  LIMIT_SAT       = 10'h3FF;
  localparam logic [6:0]  GAIN_MIN        = 7'h0A;
  localparam logic [6:0]  GAIN_MAX        = 7'h64;
  localparam logic [6:0]  GAIN_RST        = 7'h21;
  localparam logic [11:0] FILT_TC_MAX     = 12'h9C4;
  localparam logic [11:0] FILT_TC_RST     = 12'h032;
  localparam logic [15:0] IN_MAP_RST      = 16'hFF10;
  localparam logic [15:0] VIRT_MAP_RST    = 16'hFFFF;
  localparam logic [3:0]  FN_FWD_EXT      = 4'h0;
  localparam logic [3:0]  FN_REV_EXT      = 4'h1;
  localparam int          NUM_PHYS        = 6;
  localparam int          NUM_LOW_BUS     = 4;
  localparam int          FRAC_BITS       = 8;

  typedef enum logic [1:0] {
    MODE_POS = 2'b00,
    MODE_SPD = 2'b01,
    MODE_TRQ = 2'b10
  } stl_mode_t;

  typedef struct packed {
    logic [9:0] fwd;
    logic [9:0] rev;
  } stl_limits_t;

  typedef struct packed {
    logic fwd_ext;
    logic rev_ext;
  } stl_ext_t;
endpackage : stl_pkg

// ===== hdl/stl_torque_limit.sv
// Torque limit selection for one servo axis: filter, source select, clamp.
// Assumes synchronous inputs on i_clk and a host that writes settings
// through the strobe register port; read data appear one cycle after i_rd.
//
// Functional notes
// - Clamp each direction to its internal limit
// - Never exceed motor maximum torque
// - Forward input selects forward external limit
// - Reverse input selects reverse external limit
// - External limits 0..400, default 100, immediate
// - Analog limit enable honoured after restart
// - Analog limit only in speed/position
// - Analog magnitude limits both directions
// - Analog gain 10..100, default 33
// - First-order torque filter, 0..2500 units
// - Limit-active output, routed by pin allocation
// - Group one map and inversion, bits 0..7
// - Group two map and inversion, bits 8..15
// - Low-level bus enables per port
// - High-level bus enables per port
// - External inputs sampled every 2 ms
//
// Decided for this implementation: the strobed register port and the address map.
module stl_torque_limit #(
  parameter int SAMPLE_CYC = stl_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // Register port
  input  wire logic [7:0]            i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [31:0]           o_rdata,
  // Drive context
  input  wire stl_pkg::stl_mode_t    i_ctrl_mode,
  input  wire logic [9:0]            i_motor_max_pct,
  input  wire logic signed [11:0]    i_torque_ref,
  input  wire logic signed [15:0]    i_analog_torque_ref_mv,
  input  wire logic [5:0]            i_phys_in,
  // Outputs
  output logic signed [11:0]         o_torque_cmd,
  output logic                       o_limit_active_out,
  output logic      [2:0]            o_out_pins
);
  localparam logic [18:0] SAMPLE_LAST = 19'(SAMPLE_CYC - 1);
  localparam logic [11:0] TICK_LAST   = 12'(stl_pkg::FILT_TICK_CYC - 1);

  function automatic logic [9:0] min3(input logic [9:0] a, input logic [9:0] b,
                                      input logic [9:0] c);
    logic [9:0] m;
    m = (a < b) ? a : b;
    return (m < c) ? m : c;
  endfunction : min3

  function automatic logic hit(input logic [15:0] bits, input logic [31:0] map,
                               input logic [3:0] fn);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (map[i*4 +: 4] == fn && bits[i]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : hit

  // Settings
  logic [9:0]  fwd_int_q, rev_int_q, fwd_ext_q, rev_ext_q;
  logic [6:0]  gain_q;
  logic [11:0] filt_tc_q;
  logic        analog_pend_q, analog_act_q;
  logic [31:0] in_map_q, virt_map_q;
  logic [15:0] invert_q, virt_in_q;
  logic [5:0]  bus_en_q;
  logic [1:0]  out_alloc_q;

  wire wr_fwd_int  = i_wr && i_addr == stl_pkg::ADDR_FWD_INT;
  wire wr_rev_int  = i_wr && i_addr == stl_pkg::ADDR_REV_INT;
  wire wr_fwd_ext  = i_wr && i_addr == stl_pkg::ADDR_FWD_EXT;
  wire wr_rev_ext  = i_wr && i_addr == stl_pkg::ADDR_REV_EXT;
  wire wr_gain     = i_wr && i_addr == stl_pkg::ADDR_GAIN;
  wire wr_filt     = i_wr && i_addr == stl_pkg::ADDR_FILT_TC;
  wire wr_cfg      = i_wr && i_addr == stl_pkg::ADDR_CFG;
  wire wdata_lim_ok = i_wdata <= 32'(stl_pkg::LIMIT_MAX);
  wire wdata_gain_ok = i_wdata >= 32'(stl_pkg::GAIN_MIN) && i_wdata <= 32'(stl_pkg::GAIN_MAX);
  wire wdata_tc_ok  = i_wdata <= 32'(stl_pkg::FILT_TC_MAX);
  wire restart_req  = wr_cfg && i_wdata[stl_pkg::CFG_RESTART_BIT];

  // Limits take new in-range values at once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fwd_int_q <= stl_pkg::INT_LIMIT_RST;
      rev_int_q <= stl_pkg::INT_LIMIT_RST;
      fwd_ext_q <= stl_pkg::EXT_LIMIT_RST;
      rev_ext_q <= stl_pkg::EXT_LIMIT_RST;
    end else begin
      if (wr_fwd_int && wdata_lim_ok) fwd_int_q <= i_wdata[9:0];
      if (wr_rev_int && wdata_lim_ok) rev_int_q <= i_wdata[9:0];
      if (wr_fwd_ext && wdata_lim_ok) fwd_ext_q <= i_wdata[9:0];
      if (wr_rev_ext && wdata_lim_ok) rev_ext_q <= i_wdata[9:0];
    end
  end

  // Gain and filter constant, out of range ignored
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gain_q    <= stl_pkg::GAIN_RST;
      filt_tc_q <= stl_pkg::FILT_TC_RST;
    end else begin
      if (wr_gain && wdata_gain_ok) gain_q <= i_wdata[6:0];
      if (wr_filt && wdata_tc_ok) filt_tc_q <= i_wdata[11:0];
    end
  end

  // Active copy loads the enable bit written along with the restart, and only on restart
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      analog_pend_q <= 1'b0;
      analog_act_q  <= 1'b0;
    end else begin
      if (wr_cfg) analog_pend_q <= i_wdata[stl_pkg::CFG_ANALOG_EN_BIT];
      if (restart_req) analog_act_q <= i_wdata[stl_pkg::CFG_ANALOG_EN_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_map_q    <= {16'hFFFF, stl_pkg::IN_MAP_RST};
      virt_map_q  <= {stl_pkg::VIRT_MAP_RST, stl_pkg::VIRT_MAP_RST};
      invert_q    <= 16'h0000;
      bus_en_q    <= 6'h00;
      virt_in_q   <= 16'h0000;
      out_alloc_q <= 2'h0;
    end else begin
      if (i_wr && i_addr == stl_pkg::ADDR_IN_MAP) in_map_q <= i_wdata;
      if (i_wr && i_addr == stl_pkg::ADDR_VIRT_MAP) virt_map_q <= i_wdata;
      if (i_wr && i_addr == stl_pkg::ADDR_INVERT) invert_q <= i_wdata[15:0];
      if (i_wr && i_addr == stl_pkg::ADDR_BUS_EN) bus_en_q <= i_wdata[5:0];
      if (i_wr && i_addr == stl_pkg::ADDR_VIRT_IN) virt_in_q <= i_wdata[15:0];
      if (i_wr && i_addr == stl_pkg::ADDR_OUT_ALLOC) out_alloc_q <= i_wdata[1:0];
    end
  end

  // Input bits: ports under bus control take the virtual bit instead of the pin
  logic [15:0] raw_bits;
  logic [15:0] in_bits;
  always_comb begin
    raw_bits = virt_in_q;
    for (int i = 0; i < stl_pkg::NUM_PHYS; i++) begin
      raw_bits[i] = bus_en_q[i] ? virt_in_q[i] : i_phys_in[i];
    end
  end
  assign in_bits = raw_bits ^ invert_q;

  wire fwd_now = hit(in_bits, in_map_q, stl_pkg::FN_FWD_EXT)
              || hit({8'h00, in_bits[15:8]}, virt_map_q, stl_pkg::FN_FWD_EXT);
  wire rev_now = hit(in_bits, in_map_q, stl_pkg::FN_REV_EXT)
              || hit({8'h00, in_bits[15:8]}, virt_map_q, stl_pkg::FN_REV_EXT);

  // External inputs are looked at once per sample period
  logic [18:0]       samp_cnt_q;
  stl_pkg::stl_ext_t ext_q;
  wire samp_tick = samp_cnt_q == SAMPLE_LAST;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      samp_cnt_q <= 19'h0_0000;
      ext_q      <= '0;
    end else begin
      samp_cnt_q <= samp_tick ? 19'h0_0000 : samp_cnt_q + 19'h0_0001;
      if (samp_tick) ext_q <= '{fwd_ext: fwd_now, rev_ext: rev_now};
    end
  end

  // Magnitude of the analog input scaled by the gain
  wire [15:0] analog_abs = i_analog_torque_ref_mv[15] ? 16'(-i_analog_torque_ref_mv)
                                                      : 16'(i_analog_torque_ref_mv);
  wire [15:0] analog_pct = analog_abs / 16'(gain_q);
  wire [9:0]  analog_lim = (analog_pct > 16'(stl_pkg::LIMIT_SAT)) ? stl_pkg::LIMIT_SAT
                                                                  : analog_pct[9:0];
  // Analog limit ignored in torque control
  wire analog_use = analog_act_q && (i_ctrl_mode == stl_pkg::MODE_SPD
                                   || i_ctrl_mode == stl_pkg::MODE_POS);
  wire [9:0] analog_cap = analog_use ? analog_lim : stl_pkg::LIMIT_SAT;

  wire [9:0] fwd_sel = ext_q.fwd_ext ? fwd_ext_q : fwd_int_q;
  wire [9:0] rev_sel = ext_q.rev_ext ? rev_ext_q : rev_int_q;
  // Smallest of selected, motor max and analog
  stl_pkg::stl_limits_t eff;
  assign eff.fwd = min3(fwd_sel, i_motor_max_pct, analog_cap);
  assign eff.rev = min3(rev_sel, i_motor_max_pct, analog_cap);

  // First-order filter stepped every filter time unit
  logic [11:0]        tick_cnt_q;
  logic signed [19:0] filt_q;
  wire                filt_tick = tick_cnt_q == TICK_LAST;
  wire signed [20:0]  filt_diff = 21'(signed'({i_torque_ref, 8'h00})) - 21'(filt_q);
  wire signed [20:0]  filt_step = filt_diff / signed'(21'({1'b0, filt_tc_q} + 13'h0001));
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 12'h000;
      filt_q     <= 20'h0_0000;
    end else begin
      tick_cnt_q <= filt_tick ? 12'h000 : tick_cnt_q + 12'h001;
      if (filt_tick) filt_q <= 20'(21'(filt_q) + filt_step);
    end
  end

  wire signed [11:0] filt_out = filt_q[19:stl_pkg::FRAC_BITS];
  wire signed [12:0] fwd_s    = signed'({3'b000, eff.fwd});
  wire signed [12:0] rev_s    = -signed'({3'b000, eff.rev});
  wire               over_fwd = 13'(filt_out) > fwd_s;
  wire               over_rev = 13'(filt_out) < rev_s;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_torque_cmd       <= 12'h000;
      o_limit_active_out <= 1'b0;
    end else begin
      o_torque_cmd       <= over_fwd ? fwd_s[11:0] : (over_rev ? rev_s[11:0] : filt_out);
      o_limit_active_out <= over_fwd || over_rev;
    end
  end
  // Output allocation, zero leaves all pins off
  always_comb begin
    o_out_pins = 3'b000;
    if (out_alloc_q != 2'h0) o_out_pins[out_alloc_q - 2'h1] = o_limit_active_out;
  end

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (i_addr)
      stl_pkg::ADDR_FWD_INT:   rd_mux = 32'(fwd_int_q);
      stl_pkg::ADDR_REV_INT:   rd_mux = 32'(rev_int_q);
      stl_pkg::ADDR_FWD_EXT:   rd_mux = 32'(fwd_ext_q);
      stl_pkg::ADDR_REV_EXT:   rd_mux = 32'(rev_ext_q);
      stl_pkg::ADDR_GAIN:      rd_mux = 32'(gain_q);
      stl_pkg::ADDR_FILT_TC:   rd_mux = 32'(filt_tc_q);
      stl_pkg::ADDR_CFG:       rd_mux = 32'(analog_pend_q);
      stl_pkg::ADDR_IN_MAP:    rd_mux = in_map_q;
      stl_pkg::ADDR_VIRT_MAP:  rd_mux = virt_map_q;
      stl_pkg::ADDR_INVERT:    rd_mux = 32'(invert_q);
      stl_pkg::ADDR_BUS_EN:    rd_mux = 32'(bus_en_q);
      stl_pkg::ADDR_VIRT_IN:   rd_mux = 32'(virt_in_q);
      stl_pkg::ADDR_STATUS:    rd_mux = 32'({analog_act_q, ext_q, o_limit_active_out});
      stl_pkg::ADDR_EFF_LIM:   rd_mux = (32'(eff.rev) << stl_pkg::EFF_REV_LSB) | 32'(eff.fwd);
      stl_pkg::ADDR_TORQUE:    rd_mux = 32'(unsigned'(o_torque_cmd));
      stl_pkg::ADDR_OUT_ALLOC: rd_mux = 32'(out_alloc_q);
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_rdata <= 32'h0000_0000;
    else o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_fwd_clamp_bound: assert property (
    $past(over_fwd) |-> o_torque_cmd == $past(fwd_s[11:0]))
    else $error("forward clamp value wrong");
  a_motor_max_cap: assert property (
    eff.fwd <= i_motor_max_pct && eff.rev <= i_motor_max_pct)
    else $error("limit above motor maximum");
  a_fwd_ext_select: assert property (
    ext_q.fwd_ext && !analog_use && fwd_ext_q <= i_motor_max_pct |-> eff.fwd == fwd_ext_q)
    else $error("forward external limit not used");
  a_rev_int_select: assert property (
    !ext_q.rev_ext && !analog_use && rev_int_q <= i_motor_max_pct |-> eff.rev == rev_int_q)
    else $error("reverse internal limit not used");
  a_ext_range_kept: assert property (
    fwd_ext_q <= stl_pkg::LIMIT_MAX && rev_ext_q <= stl_pkg::LIMIT_MAX)
    else $error("external limit out of range");
  a_analog_restart_only: assert property (
    !restart_req |=> $stable(analog_act_q))
    else $error("analog enable changed without restart");
  a_analog_torque_mode: assert property (
    i_ctrl_mode == stl_pkg::MODE_TRQ |-> !analog_use)
    else $error("analog limit used in torque mode");
  a_analog_both_dirs: assert property (
    analog_use && analog_lim < i_motor_max_pct && analog_lim < fwd_sel
      && analog_lim < rev_sel |-> eff.fwd == analog_lim && eff.rev == analog_lim)
    else $error("analog limit not applied to both directions");
  a_gain_range_kept: assert property (
    gain_q >= stl_pkg::GAIN_MIN && gain_q <= stl_pkg::GAIN_MAX)
    else $error("gain out of range");
  a_active_matches: assert property (
    o_limit_active_out == (o_torque_cmd != $past(filt_out)))
    else $error("limit active flag disagrees with clamp");
  a_ext_sample_hold: assert property (
    !$past(samp_tick) |-> $stable(ext_q))
    else $error("external inputs changed between samples");
  a_rev_clamp_bound: assert property (
    $past(over_rev) |-> o_torque_cmd == $past(rev_s[11:0]))
    else $error("reverse clamp value wrong");
  a_fwd_int_select: assert property (
    !ext_q.fwd_ext && !analog_use && fwd_int_q <= i_motor_max_pct |-> eff.fwd == fwd_int_q)
    else $error("forward internal limit not used");
  a_rev_ext_select: assert property (
    ext_q.rev_ext && !analog_use && rev_ext_q <= i_motor_max_pct |-> eff.rev == rev_ext_q)
    else $error("reverse external limit not used");
  // Read data fall back to zero so a stale word is never taken for an answer
  a_rdata_one_cycle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data stood beyond its cycle");
  // Filter state moves only on its tick; any other update would skew the time constant
  a_filter_hold_between: assert property (
    !$past(filt_tick) |-> $stable(filt_q))
    else $error("filter moved between ticks");
  a_filter_tc_zero: assert property (
    $past(filt_tick) && $past(filt_tc_q) == 12'h000
      |-> filt_q == $past({i_torque_ref, 8'h00}))
    else $error("zero time constant does not follow reference");
  a_filter_tc_range: assert property (
    filt_tc_q <= stl_pkg::FILT_TC_MAX)
    else $error("filter time constant out of range");
  // Routing checked end to end: pin or virtual bit, inversion, then function code
  a_group_a_pin: assert property (
    !bus_en_q[0] && in_map_q[3:0] == stl_pkg::FN_FWD_EXT
      && (i_phys_in[0] ^ invert_q[0]) |-> fwd_now)
    else $error("group one pin not routed to forward function");
  a_group_b_virt: assert property (
    virt_map_q[3:0] == stl_pkg::FN_FWD_EXT && (virt_in_q[8] ^ invert_q[8]) |-> fwd_now)
    else $error("group two virtual bit not routed to forward function");
  a_low_bus_steer: assert property (
    bus_en_q[1] && in_map_q[7:4] == stl_pkg::FN_REV_EXT
      && (virt_in_q[1] ^ invert_q[1]) |-> rev_now)
    else $error("low bus enable did not steer virtual bit");
  a_high_bus_steer: assert property (
    bus_en_q[4] && in_map_q[19:16] == stl_pkg::FN_REV_EXT
      && (virt_in_q[4] ^ invert_q[4]) |-> rev_now)
    else $error("high bus enable did not steer virtual bit");
  a_pins_off_unalloc: assert property (
    out_alloc_q == 2'h0 |-> o_out_pins == 3'h0)
    else $error("output pin driven without allocation");
  a_pins_follow_flag: assert property (
    out_alloc_q != 2'h0 |-> (|o_out_pins) == o_limit_active_out)
    else $error("allocated pin disagrees with limit flag");
endmodule : stl_torque_limit

// ===== tb/stl_host_model.sv
// Host controller model: drives the external limit pins and the analog limit input.
// Assumes the bench sets the requested levels; changes land just after a rising edge.
module stl_host_model (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  // Requests from the bench
  input  wire logic               i_fwd_on,
  input  wire logic               i_rev_on,
  input  wire logic signed [15:0] i_analog_mv,
  // Pins toward the drive
  output logic             [5:0]  o_phys_in,
  output logic signed      [15:0] o_analog_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels held steady
  // Levels, not pulses, so a slow sampler in the drive cannot miss them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phys_in   <= 6'h00;
      o_analog_mv <= 16'h0000;
    end else begin
      o_phys_in   <= {4'h0, i_rev_on, i_fwd_on};
      o_analog_mv <= i_analog_mv;
    end
  end
endmodule : stl_host_model

// ===== tb/test_stl_torque_limit.sv
// Self-checking bench for the torque limit selector.
// Assumes a 200 MHz clock and a shortened external sample period.
module test_stl_torque_limit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SMP = 16;
  logic                      i_clk;
  logic                      i_rst_n;
  logic               [7:0]  i_addr;
  logic               [31:0] i_wdata;
  logic                      i_wr;
  logic                      i_rd;
  logic               [31:0] o_rdata;
  stl_pkg::stl_mode_t        i_ctrl_mode;
  logic               [9:0]  i_motor_max_pct;
  logic signed        [11:0] i_torque_ref;
  logic signed        [15:0] analog_mv;
  logic signed        [15:0] pin_mv;
  logic               [5:0]  pin_in;
  logic signed        [11:0] o_torque_cmd;
  logic                      o_limit_active_out;
  logic               [2:0]  o_out_pins;
  logic                      fwd_on;
  logic                      rev_on;
  int                        failures;
  int                        cmp_count;

  stl_torque_limit #(.SAMPLE_CYC(SMP)) stl_torque_limit_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ctrl_mode(i_ctrl_mode),
    .i_motor_max_pct(i_motor_max_pct), .i_torque_ref(i_torque_ref),
    .i_analog_torque_ref_mv(pin_mv), .i_phys_in(pin_in), .o_torque_cmd(o_torque_cmd),
    .o_limit_active_out(o_limit_active_out), .o_out_pins(o_out_pins));

  stl_host_model stl_host_model_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_fwd_on(fwd_on), .i_rev_on(rev_on),
    .i_analog_mv(analog_mv), .o_phys_in(pin_in), .o_analog_mv(pin_mv));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic tally_and_finish();
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    check(what, o_rdata, exp);
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wait_cyc

  task automatic check_cmd(input logic [11:0] exp, input logic act);
    check("torque", {20'h0_0000, o_torque_cmd}, {20'h0_0000, exp});
    check("active", {31'h0, o_limit_active_out}, {31'h0, act});
  endtask : check_cmd

  task automatic check_reset();
    rd(stl_pkg::ADDR_FWD_INT, 32'h0000_015E, "fwd int");
    rd(stl_pkg::ADDR_REV_INT, 32'h0000_015E, "rev int");
    rd(stl_pkg::ADDR_FWD_EXT, 32'h0000_0064, "fwd ext");
    rd(stl_pkg::ADDR_REV_EXT, 32'h0000_0064, "rev ext");
    rd(stl_pkg::ADDR_GAIN, 32'h0000_0021, "gain");
    rd(stl_pkg::ADDR_FILT_TC, 32'h0000_0032, "filter tc");
    rd(stl_pkg::ADDR_CFG, 32'h0000_0000, "cfg");
    rd(8'h40, 32'h0000_0000, "unmapped");
    rd(stl_pkg::ADDR_EFF_LIM, 32'h015E_015E, "eff reset");
  endtask : check_reset

  task automatic check_refused();
    wr(stl_pkg::ADDR_FWD_EXT, 32'h0000_0191);
    rd(stl_pkg::ADDR_FWD_EXT, 32'h0000_0064, "ext over");
    wr(stl_pkg::ADDR_FWD_EXT, 32'h0000_0190);
    rd(stl_pkg::ADDR_FWD_EXT, 32'h0000_0190, "ext max");
    wr(stl_pkg::ADDR_GAIN, 32'h0000_0009);
    rd(stl_pkg::ADDR_GAIN, 32'h0000_0021, "gain low");
    wr(stl_pkg::ADDR_GAIN, 32'h0000_0064);
    rd(stl_pkg::ADDR_GAIN, 32'h0000_0064, "gain max");
    wr(stl_pkg::ADDR_FILT_TC, 32'h0000_09C5);
    rd(stl_pkg::ADDR_FILT_TC, 32'h0000_0032, "tc over");
    wr(stl_pkg::ADDR_FILT_TC, 32'h0000_0000);
    rd(stl_pkg::ADDR_FILT_TC, 32'h0000_0000, "tc zero");
    wr(stl_pkg::ADDR_FWD_EXT, 32'h0000_0064);
    wr(stl_pkg::ADDR_GAIN, 32'h0000_0021);
  endtask : check_refused

  task automatic check_clamp();
    i_torque_ref <= 12'h0C8;
    wr(stl_pkg::ADDR_FWD_INT, 32'h0000_0096);
    wr(stl_pkg::ADDR_OUT_ALLOC, 32'h0000_0002);
    wait_cyc(stl_pkg::FILT_TICK_CYC + 5);
    check_cmd(12'h096, 1'b1);
    check("pins", {29'h0, o_out_pins}, 32'h0000_0002);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h015E_0096, "eff fwd int");
    @(posedge i_clk);
    i_motor_max_pct <= 10'h050;
    wait_cyc(3);
    check_cmd(12'h050, 1'b1);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h0050_0050, "eff motor max");
    @(posedge i_clk);
    i_motor_max_pct <= 10'h190;
    wr(stl_pkg::ADDR_FWD_INT, 32'h0000_0190);
    wait_cyc(3);
    check_cmd(12'h0C8, 1'b0);
    check("pins off", {29'h0, o_out_pins}, 32'h0000_0000);
    @(posedge i_clk);
    i_torque_ref <= 12'hF38;
    wr(stl_pkg::ADDR_REV_INT, 32'h0000_0078);
    wait_cyc(stl_pkg::FILT_TICK_CYC + 5);
    check_cmd(12'hF88, 1'b1);
  endtask : check_clamp

  task automatic check_external();
    wr(stl_pkg::ADDR_REV_EXT, 32'h0000_003C);
    rev_on <= 1'b1;
    wait_cyc(SMP + 4);
    check_cmd(12'hFC4, 1'b1);
    rd(stl_pkg::ADDR_STATUS, 32'h0000_0003, "status");
    @(posedge i_clk);
    fwd_on <= 1'b1;
    wait_cyc(SMP + 4);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h003C_0064, "eff ext both");
    @(posedge i_clk);
    fwd_on <= 1'b0;
    rev_on <= 1'b0;
    wait_cyc(SMP + 4);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h0078_0190, "eff ext off");
  endtask : check_external

  task automatic check_input_map();
    wr(stl_pkg::ADDR_INVERT, 32'h0000_0001);
    wait_cyc(SMP + 4);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h0078_0064, "eff invert");
    wr(stl_pkg::ADDR_INVERT, 32'h0000_0000);
    wr(stl_pkg::ADDR_BUS_EN, 32'h0000_0002);
    wr(stl_pkg::ADDR_VIRT_IN, 32'h0000_0002);
    wait_cyc(SMP + 4);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h003C_0190, "eff bus low");
    wr(stl_pkg::ADDR_VIRT_MAP, 32'hFFFF_FFF0);
    wr(stl_pkg::ADDR_IN_MAP, 32'hFFF1_FF10);
    wr(stl_pkg::ADDR_BUS_EN, 32'h0000_0010);
    wr(stl_pkg::ADDR_VIRT_IN, 32'h0000_0110);
    wait_cyc(SMP + 4);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h003C_0064, "eff bus high");
    wr(stl_pkg::ADDR_VIRT_IN, 32'h0000_0000);
    wait_cyc(SMP + 4);
  endtask : check_input_map

  task automatic check_analog();
    @(posedge i_clk);
    analog_mv <= 16'hFC18;
    wr(stl_pkg::ADDR_CFG, 32'h0000_0001);
    wait_cyc(3);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h0078_0190, "eff pending");
    rd(stl_pkg::ADDR_CFG, 32'h0000_0001, "cfg pending");
    wr(stl_pkg::ADDR_CFG, 32'h0000_0003);
    wait_cyc(3);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h001E_001E, "eff analog");
    check_cmd(12'hFE2, 1'b1);
    @(posedge i_clk);
    i_ctrl_mode <= stl_pkg::MODE_TRQ;
    wait_cyc(3);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h0078_0190, "eff torque mode");
    @(posedge i_clk);
    i_ctrl_mode <= stl_pkg::MODE_SPD;
    wait_cyc(3);
    rd(stl_pkg::ADDR_EFF_LIM, 32'h001E_001E, "eff speed mode");
  endtask : check_analog

  initial begin
    repeat (100000) @(posedge i_clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    failures        = 0;
    cmp_count       = 0;
    i_rst_n         = 1'b0;
    i_addr          = 8'h00;
    i_wdata         = 32'h0000_0000;
    i_wr            = 1'b0;
    i_rd            = 1'b0;
    i_ctrl_mode     = stl_pkg::MODE_POS;
    i_motor_max_pct = 10'h190;
    i_torque_ref    = 12'h000;
    analog_mv       = 16'h0000;
    fwd_on          = 1'b0;
    rev_on          = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    check_reset();
    check_refused();
    check_clamp();
    check_external();
    check_input_map();
    check_analog();
    tally_and_finish();
  end
endmodule : test_stl_torque_limit
